// [dcr_params.svh]
// constants for the converter configuration register bank
`ifndef DCR_PARAMS_SVH
`define DCR_PARAMS_SVH

// register offsets on the serial configuration interface
`define DCR_ADDR_SHUTOFF     7'h02
`define DCR_ADDR_SCALE       7'h03
`define DCR_ADDR_RESULT      7'h04

// reset values and writable-bit masks
`define DCR_RST_SHUTOFF      16'h7000
`define DCR_RST_SCALE        16'hF000
`define DCR_WMASK_SHUTOFF    16'h70FA
`define DCR_WMASK_SCALE      16'hF001

// shutoff and format register fields
`define DCR_BIT_DACCLK_EN    14
`define DCR_BIT_DATACLK_EN   13
`define DCR_BIT_COLLIDE_EN   12
`define DCR_BIT_FOUR_WIRE    7
`define DCR_BIT_MIX_EN       6
`define DCR_BIT_MIX_GAIN     5
`define DCR_BIT_NCO_EN       4
`define DCR_BIT_REVBUS       3
`define DCR_BIT_TWOS         1

// scale and transmit register fields
`define DCR_BIT_COARSE_HI    15
`define DCR_BIT_COARSE_LO    12
`define DCR_BIT_SIF_TX       0

// alarm mask register bit positions
`define DCR_MASK_COLLIDE     13
`define DCR_MASK_DACCLK      10
`define DCR_MASK_DATACLK     9
`define DCR_MASK_OUTPUT      8

// serial frame layout and output code
`define DCR_FRAME_BITS       5'd24
`define DCR_INSTR_BITS       5'd8
`define DCR_MID_SCALE        16'h8000

`endif

// [dcr_pkg.sv]
// types shared by the configuration register bank modules
package dcr_pkg;

   // serial configuration frame phases
   typedef enum logic [1:0] {
      sif_idle,
      sif_instr,
      sif_data,
      sif_done
   } dcr_sif_state_type;

   // one input bus word
   typedef logic [15:0] dcr_word_type;

endpackage : dcr_pkg

// [dcr_ctrl_if.sv]
// control carrier between the register bank and its datapath helpers
interface dcr_ctrl_if;
   logic                 bit_reverse;
   logic                 twos_format;
   logic                 shutoff;
   logic                 test_enable;
   logic                 results_clear;
   dcr_pkg::dcr_word_type results;

   modport regs    (output bit_reverse, twos_format, shutoff, test_enable, results_clear,
                    input results);
   modport guard   (input bit_reverse, twos_format, shutoff);
   modport collect (input test_enable, results_clear, output results);
endinterface : dcr_ctrl_if

// [dcr_pattern_check.sv]
// sticky per-bit pattern checker result collector
module dcr_pattern_check #(
   parameter int WIDTH = 16
) (
   // clock
   input  wire logic             i_clk,
   // input bus words and their expected pattern
   input  wire logic             i_data_valid,
   input  wire logic [WIDTH-1:0] i_first_word,
   input  wire logic [WIDTH-1:0] i_second_word,
   input  wire logic [WIDTH-1:0] i_first_expect,
   input  wire logic [WIDTH-1:0] i_second_expect,
   // control carrier
   dcr_ctrl_if.collect           ctrl
);

   logic [WIDTH-1:0] fail_bits;

   // a bit fails when it differs on either bus, checked only in test mode
   always_comb begin
      fail_bits = '0;
      if (ctrl.test_enable && i_data_valid) begin
         fail_bits = (i_first_word ^ i_first_expect) | (i_second_word ^ i_second_expect);
      end
   end

   // no reset on purpose: the register has no defined power-up value
   // a new failure wins over a clear in the same cycle
   always_ff @(posedge i_clk) begin
      ctrl.results <= (ctrl.results_clear ? '0 : ctrl.results) | fail_bits;
   end

endmodule : dcr_pattern_check

// [dcr_output_guard.sv]
// input word reorder, format normalise and mid-scale forcing
`include "dcr_params.svh"

module dcr_output_guard #(
   parameter int NUM_BUS = 2,
   parameter int WIDTH   = 16
) (
   // clock and reset
   input  wire logic                           i_clk,
   input  wire logic                           i_rst_n,
   // raw words from the input buses
   input  wire logic                           i_data_valid,
   input  wire logic [NUM_BUS-1:0][WIDTH-1:0]  i_words,
   // control carrier
   dcr_ctrl_if.guard                           ctrl,
   // offset-binary words towards the converter channels
   output logic      [NUM_BUS-1:0][WIDTH-1:0]  o_words
);

   genvar bus_i;
   genvar bit_i;
   generate
      for (bus_i = 0; bus_i < NUM_BUS; bus_i++) begin : g_bus
         logic [WIDTH-1:0] reversed;
         logic [WIDTH-1:0] ordered;
         for (bit_i = 0; bit_i < WIDTH; bit_i++) begin : g_bit
            assign reversed[bit_i] = i_words[bus_i][WIDTH-1-bit_i];
         end
         assign ordered = ctrl.bit_reverse ? reversed : i_words[bus_i];

         // channel data is held as offset binary; two's complement flips the sign bit
         always_ff @(posedge i_clk or negedge i_rst_n) begin
            if (!i_rst_n) begin
               o_words[bus_i] <= `DCR_MID_SCALE;
            end else if (ctrl.shutoff) begin
               o_words[bus_i] <= `DCR_MID_SCALE;
            end else if (i_data_valid) begin
               o_words[bus_i] <= ordered ^ {ctrl.twos_format, {(WIDTH-1){1'b0}}};
            end
         end
      end
   endgenerate

endmodule : dcr_output_guard

// [dcr_config_regs.sv]
// converter configuration register bank behind the serial config interface
//
// Function
// - converter clock loss enable shuts outputs off
// - data clock loss enable shuts outputs off
// - collision enable lets FIFO collision shut off
// - bit 7 picks four-wire or three-wire serial
// - mixer active only while its enable set
// - gain bit adds 6dB to mixer output
// - bit 4 enables oscillator; coarse mixing unaffected
// - reverse bit order of every input word
// - bit 1 picks two's complement or offset binary
// - coarse code sets full-scale current as code+1
// - software transmit bit forces internal enable high
// - transmit on when software bit or pin high
// - result bit set where either bus failed
// - result bits map to matching input bit positions
// - result register unreset, cleared by any write
// - shutoff register resets to 0x7000
// - scale register resets to 0xF000
// - pattern test keeps outputs off, checker runs
// - shutoff alarm forces every channel to mid-scale
`include "dcr_params.svh"

module dcr_config_regs #(
   parameter int WIDTH   = 16,
   parameter int NUM_BUS = 2
) (
   // clock and reset
   input  wire logic             i_clk,
   input  wire logic             i_rst_n,
   // serial configuration interface
   input  wire logic             i_sif_clk,
   input  wire logic             i_sif_enable_n,
   input  wire logic             i_sif_data_in,
   output logic                  o_sif_data_out,
   output logic                  o_sif_data_oe,
   output logic                  o_sif_serial_out,
   // alarm sources and mask from the neighbouring alarm logic
   input  wire logic             i_dacclk_lost,
   input  wire logic             i_dataclk_lost,
   input  wire logic             i_fifo_collision,
   input  wire logic [15:0]      i_alarm_mask_register,
   // pattern test control from the neighbouring register
   input  wire logic             i_pattern_test_enable,
   input  wire logic [WIDTH-1:0] i_first_expect,
   input  wire logic [WIDTH-1:0] i_second_expect,
   // input data buses
   input  wire logic             i_data_valid,
   input  wire logic [WIDTH-1:0] i_first_pair_input_bus,
   input  wire logic [WIDTH-1:0] i_second_pair_input_bus,
   input  wire logic             i_transmit_enable_pin,
   // configuration outputs
   output logic                  o_serial_four_wire_select,
   output logic                  o_mixer_enable,
   output logic                  o_mixer_gain_6db,
   output logic                  o_nco_enable,
   output logic [3:0]            o_coarse_current_code,
   output logic [4:0]            o_full_scale_steps,
   output logic                  o_transmit_enable_internal,
   output logic                  o_transmit_active,
   output logic                  o_output_shutoff,
   // channel data
   output logic [WIDTH-1:0]      o_first_pair_word,
   output logic [WIDTH-1:0]      o_second_pair_word
);

   // register storage
   logic [15:0]                   shutoff_ctrl_reg;
   logic [15:0]                   scale_ctrl_reg;

   // serial frame engine state
   dcr_pkg::dcr_sif_state_type    sif_state_reg;
   dcr_pkg::dcr_sif_state_type    sif_state_next;
   logic                          sif_clk_reg;
   logic [4:0]                    bit_cnt_reg;
   logic [22:0]                   frame_reg;
   logic                          read_op_reg;
   logic [6:0]                    addr_reg;
   logic [15:0]                   rd_shift_reg;
   logic                          out_bit_reg;

   // decoded strobes
   logic                          sif_rise;
   logic                          sif_fall;
   logic                          instr_done;
   logic                          write_fire;
   logic [15:0]                   write_data;
   logic [6:0]                    instr_addr;
   logic [15:0]                   read_value;

   // datapath helpers
   dcr_ctrl_if                    ctrl ();
   logic [NUM_BUS-1:0][WIDTH-1:0] bus_words;
   logic [NUM_BUS-1:0][WIDTH-1:0] chan_words;

   // serial pins are synchronous to i_clk, so one stage is enough for edges
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         sif_clk_reg <= 1'b0;
      end else begin
         sif_clk_reg <= i_sif_clk;
      end
   end

   assign sif_rise = i_sif_clk & ~sif_clk_reg;
   assign sif_fall = ~i_sif_clk & sif_clk_reg;

   // frame decode: first bit is read/write, then 7 address bits, then 16 data
   assign instr_done = (sif_state_reg == dcr_pkg::sif_instr) && sif_rise
                       && (bit_cnt_reg == `DCR_INSTR_BITS - 5'd1);
   assign instr_addr = {frame_reg[5:0], i_sif_data_in};
   assign write_fire = (sif_state_reg == dcr_pkg::sif_data) && sif_rise && !read_op_reg
                       && (bit_cnt_reg == `DCR_FRAME_BITS - 5'd1);
   assign write_data = {frame_reg[14:0], i_sif_data_in};

   // frame state; a deasserted enable aborts any partial frame
   always_comb begin
      sif_state_next = sif_state_reg;
      case (sif_state_reg)
         dcr_pkg::sif_idle: begin
            sif_state_next = dcr_pkg::sif_instr;
         end
         dcr_pkg::sif_instr: begin
            if (instr_done) begin
               sif_state_next = dcr_pkg::sif_data;
            end
         end
         dcr_pkg::sif_data: begin
            if (sif_rise && (bit_cnt_reg == `DCR_FRAME_BITS - 5'd1)) begin
               sif_state_next = dcr_pkg::sif_done;
            end
         end
         dcr_pkg::sif_done: begin
            sif_state_next = dcr_pkg::sif_done;
         end
         default: begin
            sif_state_next = dcr_pkg::sif_idle;
         end
      endcase
      if (i_sif_enable_n) begin
         sif_state_next = dcr_pkg::sif_idle;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         sif_state_reg <= dcr_pkg::sif_idle;
      end else begin
         sif_state_reg <= sif_state_next;
      end
   end

   // bit counter and incoming shift register
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         bit_cnt_reg <= 5'h00;
         frame_reg   <= 23'h000000;
      end else if (i_sif_enable_n || sif_state_reg == dcr_pkg::sif_idle) begin
         bit_cnt_reg <= 5'h00;
      end else if (sif_rise && sif_state_reg != dcr_pkg::sif_done) begin
         bit_cnt_reg <= bit_cnt_reg + 5'd1;
         frame_reg   <= {frame_reg[21:0], i_sif_data_in};
      end
   end

   // latch the instruction once its eighth bit arrives
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         read_op_reg <= 1'b0;
         addr_reg    <= 7'h00;
      end else if (instr_done) begin
         read_op_reg <= frame_reg[6];
         addr_reg    <= instr_addr;
      end
   end

   // read mux; unmapped addresses and reserved bits read as zero
   always_comb begin
      case (instr_addr)
         `DCR_ADDR_SHUTOFF: read_value = shutoff_ctrl_reg;
         `DCR_ADDR_SCALE:   read_value = scale_ctrl_reg;
         `DCR_ADDR_RESULT:  read_value = ctrl.results;
         default:           read_value = 16'h0000;
      endcase
   end

   // read data goes out msb first, one bit per falling serial clock edge
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rd_shift_reg <= 16'h0000;
         out_bit_reg  <= 1'b0;
      end else if (instr_done) begin
         rd_shift_reg <= read_value;
      end else if (sif_fall && sif_state_reg == dcr_pkg::sif_data && read_op_reg) begin
         out_bit_reg  <= rd_shift_reg[15];
         rd_shift_reg <= {rd_shift_reg[14:0], 1'b0};
      end
   end

   // in four-wire mode read data leaves on its own pin, else on the shared line
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_sif_data_oe <= 1'b0;
      end else begin
         o_sif_data_oe <= !i_sif_enable_n && read_op_reg
                          && sif_state_next == dcr_pkg::sif_data
                          && !shutoff_ctrl_reg[`DCR_BIT_FOUR_WIRE];
      end
   end

   assign o_sif_data_out   = shutoff_ctrl_reg[`DCR_BIT_FOUR_WIRE] ? 1'b0 : out_bit_reg;
   assign o_sif_serial_out = shutoff_ctrl_reg[`DCR_BIT_FOUR_WIRE] ? out_bit_reg : 1'b0;

   // shutoff and format register; reserved bits never store
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         shutoff_ctrl_reg <= `DCR_RST_SHUTOFF;
      end else if (write_fire && addr_reg == `DCR_ADDR_SHUTOFF) begin
         shutoff_ctrl_reg <= write_data & `DCR_WMASK_SHUTOFF;
      end
   end

   // scale and transmit register
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         scale_ctrl_reg <= `DCR_RST_SCALE;
      end else if (write_fire && addr_reg == `DCR_ADDR_SCALE) begin
         scale_ctrl_reg <= write_data & `DCR_WMASK_SCALE;
      end
   end

   // any write to the result register clears it, whatever the data
   assign ctrl.results_clear = write_fire && addr_reg == `DCR_ADDR_RESULT;

   // shutoff only counts when the source and output-gone alarms are unmasked
   assign o_output_shutoff =
        (shutoff_ctrl_reg[`DCR_BIT_DACCLK_EN] && i_dacclk_lost
         && !i_alarm_mask_register[`DCR_MASK_DACCLK]
         && !i_alarm_mask_register[`DCR_MASK_OUTPUT])
      || (shutoff_ctrl_reg[`DCR_BIT_DATACLK_EN] && i_dataclk_lost
         && !i_alarm_mask_register[`DCR_MASK_DATACLK]
         && !i_alarm_mask_register[`DCR_MASK_OUTPUT])
      || (shutoff_ctrl_reg[`DCR_BIT_COLLIDE_EN] && i_fifo_collision
         && !i_alarm_mask_register[`DCR_MASK_COLLIDE]
         && !i_alarm_mask_register[`DCR_MASK_OUTPUT]);

   // the alarms stay latched outside until software clears them
   assign ctrl.shutoff = o_output_shutoff;

   // mixer, oscillator and serial width controls
   assign o_serial_four_wire_select = shutoff_ctrl_reg[`DCR_BIT_FOUR_WIRE];
   assign o_mixer_enable            = shutoff_ctrl_reg[`DCR_BIT_MIX_EN];
   assign o_mixer_gain_6db          = shutoff_ctrl_reg[`DCR_BIT_MIX_EN]
                                      && shutoff_ctrl_reg[`DCR_BIT_MIX_GAIN];
   // coarse mixing does not depend on this bit
   assign o_nco_enable              = shutoff_ctrl_reg[`DCR_BIT_NCO_EN];

   // datapath format controls
   assign ctrl.bit_reverse = shutoff_ctrl_reg[`DCR_BIT_REVBUS];
   assign ctrl.twos_format = shutoff_ctrl_reg[`DCR_BIT_TWOS];
   assign ctrl.test_enable = i_pattern_test_enable;

   // full-scale current steps, one to sixteen
   assign o_coarse_current_code = scale_ctrl_reg[`DCR_BIT_COARSE_HI:`DCR_BIT_COARSE_LO];
   assign o_full_scale_steps    = {1'b0, o_coarse_current_code} + 5'd1;

   // transmit: either source enables; pattern test keeps outputs off
   assign o_transmit_enable_internal = scale_ctrl_reg[`DCR_BIT_SIF_TX];
   assign o_transmit_active = (o_transmit_enable_internal || i_transmit_enable_pin)
                              && !i_pattern_test_enable;

   // pattern checker sees the raw pins, before reordering
   dcr_pattern_check #(
      .WIDTH (WIDTH)
   ) u_check (
      .i_clk           (i_clk),
      .i_data_valid    (i_data_valid),
      .i_first_word    (i_first_pair_input_bus),
      .i_second_word   (i_second_pair_input_bus),
      .i_first_expect  (i_first_expect),
      .i_second_expect (i_second_expect),
      .ctrl            (ctrl.collect)
   );

   // channel words
   assign bus_words[0] = i_first_pair_input_bus;
   assign bus_words[1] = i_second_pair_input_bus;

   dcr_output_guard #(
      .NUM_BUS (NUM_BUS),
      .WIDTH   (WIDTH)
   ) u_guard (
      .i_clk        (i_clk),
      .i_rst_n      (i_rst_n),
      .i_data_valid (i_data_valid),
      .i_words      (bus_words),
      .ctrl         (ctrl.guard),
      .o_words      (chan_words)
   );

   assign o_first_pair_word  = chan_words[0];
   assign o_second_pair_word = chan_words[1];

endmodule : dcr_config_regs

// [dcr_config_regs_asserts.sv]
// port-level assertions for the configuration register bank
module dcr_config_regs_asserts #(
   parameter int WIDTH = 16
) (
   // clock and reset
   input  wire logic             i_clk,
   input  wire logic             i_rst_n,
   // serial configuration interface
   input  wire logic             i_sif_enable_n,
   input  wire logic             o_sif_data_out,
   input  wire logic             o_sif_data_oe,
   input  wire logic             o_sif_serial_out,
   // alarms, mask, test and transmit pin
   input  wire logic             i_dacclk_lost,
   input  wire logic             i_dataclk_lost,
   input  wire logic             i_fifo_collision,
   input  wire logic [15:0]      i_alarm_mask_register,
   input  wire logic             i_pattern_test_enable,
   input  wire logic             i_transmit_enable_pin,
   // configuration and channel outputs
   input  wire logic             o_serial_four_wire_select,
   input  wire logic             o_mixer_enable,
   input  wire logic             o_mixer_gain_6db,
   input  wire logic [3:0]       o_coarse_current_code,
   input  wire logic [4:0]       o_full_scale_steps,
   input  wire logic             o_transmit_enable_internal,
   input  wire logic             o_transmit_active,
   input  wire logic             o_output_shutoff,
   input  wire logic [WIDTH-1:0] o_first_pair_word,
   input  wire logic [WIDTH-1:0] o_second_pair_word
);
   timeunit 1ns;
   timeprecision 100ps;

   // one domain, so clock and reset are given once
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_rst_n);

   steps_from_code_a: assert property (o_full_scale_steps == {1'b0, o_coarse_current_code} + 5'd1)
      else $error("full-scale steps differ from code plus one");
   tx_enable_or_a: assert property (o_transmit_active == ((o_transmit_enable_internal
      || i_transmit_enable_pin) && !i_pattern_test_enable))
      else $error("transmit active does not follow enables");
   shutoff_cause_a: assert property (o_output_shutoff |-> !i_alarm_mask_register[8]
      && ((i_dacclk_lost && !i_alarm_mask_register[10]) || (i_dataclk_lost
      && !i_alarm_mask_register[9]) || (i_fifo_collision && !i_alarm_mask_register[13])))
      else $error("shutoff without an unmasked alarm");
   mid_scale_a: assert property (o_output_shutoff |=> o_first_pair_word == 16'h8000
      && o_second_pair_word == 16'h8000)
      else $error("channel words not mid-scale after shutoff");
   gain_gated_a: assert property (o_mixer_gain_6db |-> o_mixer_enable)
      else $error("mixer gain active with mixer disabled");
   three_wire_out_a: assert property (!o_serial_four_wire_select |-> !o_sif_serial_out)
      else $error("separate out pin driven in three-wire mode");
   four_wire_out_a: assert property (o_serial_four_wire_select |-> !o_sif_data_oe && !o_sif_data_out)
      else $error("shared line driven in four-wire mode");
   oe_release_a: assert property (i_sif_enable_n |=> !o_sif_data_oe)
      else $error("shared line still driven after frame end");
   cfg_hold_a: assert property (i_sif_enable_n [*2] |-> $stable(o_coarse_current_code)
      && $stable(o_transmit_enable_internal) && $stable(o_mixer_enable))
      else $error("configuration changed outside a frame");
endmodule : dcr_config_regs_asserts

bind dcr_config_regs dcr_config_regs_asserts #(.WIDTH(WIDTH)) u_asserts (
   .i_clk, .i_rst_n, .i_sif_enable_n, .o_sif_data_out, .o_sif_data_oe, .o_sif_serial_out,
   .i_dacclk_lost, .i_dataclk_lost, .i_fifo_collision, .i_alarm_mask_register,
   .i_pattern_test_enable, .i_transmit_enable_pin, .o_serial_four_wire_select,
   .o_mixer_enable, .o_mixer_gain_6db, .o_coarse_current_code, .o_full_scale_steps,
   .o_transmit_enable_internal, .o_transmit_active, .o_output_shutoff,
   .o_first_pair_word, .o_second_pair_word);

// [dcr_host_model.sv]
// behavioural host controller on the serial configuration interface
module dcr_host_model (
   // clock and mode
   input  wire logic i_clk,
   input  wire logic i_four_wire,
   // serial pins
   output logic      o_sif_clk,
   output logic      o_sif_enable_n,
   output logic      o_host_data,
   input  wire logic i_shared_line,
   input  wire logic i_serial_out
);
   timeunit 1ns;
   timeprecision 100ps;

   // serial clock parked low between frames
   initial begin
      o_sif_clk      = 1'b0;
      o_sif_enable_n = 1'b1;
      o_host_data    = 1'b0;
   end

   // one 24-bit frame msb first; three cycles a phase keeps sclk above two cycles
   task automatic frame(input logic rd, input logic [6:0] addr, input logic [15:0] wdata,
                        output logic [15:0] rdata);
      logic [23:0] sh;
      sh = {rd, addr, wdata};
      rdata = 16'h0000;
      @(posedge i_clk);
      #1;
      o_sif_enable_n = 1'b0;
      for (int i = 23; i >= 0; i--) begin
         o_sif_clk = 1'b0;
         o_host_data = (rd && i < 16) ? ~o_host_data : sh[i]; // released: keeps toggling
         repeat (3) @(posedge i_clk);
         #1;
         o_sif_clk = 1'b1;
         if (i < 16) rdata[i] = i_four_wire ? i_serial_out : i_shared_line;
         repeat (3) @(posedge i_clk);
         #1;
      end
      o_sif_clk = 1'b0;
      o_sif_enable_n = 1'b1;
      o_host_data = ~o_host_data;
      repeat (2) @(posedge i_clk);
      #1;
   endtask : frame
endmodule : dcr_host_model

// [dac_config_control_regs_bench.sv]
// self-checking bench for the configuration register bank
module dac_config_control_regs_bench;
   timeunit 1ns;
   timeprecision 100ps;

   logic clk, rst_n, dk, dt, cl, test_en, valid, pin, hdata, sclk, sen_n;
   logic [15:0] mask, e1, e2, w1, w2, m02, m03, res, d, rt;
   logic [31:0] rnd;
   wire  logic sdo, oe, so, four_w, mix, gain, nco, txint, txact, shut, shared;
   wire  logic [3:0]  code;
   wire  logic [4:0]  steps;
   wire  logic [15:0] o1, o2;
   int   seed = 32'h2444;
   int   n_mismatch = 0;
   int   num_checks = 0;

   // shared line: device wins while it drives
   assign shared = oe ? sdo : hdata;

   dcr_config_regs dut (.i_clk(clk), .i_rst_n(rst_n), .i_sif_clk(sclk),
      .i_sif_enable_n(sen_n), .i_sif_data_in(shared), .o_sif_data_out(sdo),
      .o_sif_data_oe(oe), .o_sif_serial_out(so), .i_dacclk_lost(dk), .i_dataclk_lost(dt),
      .i_fifo_collision(cl), .i_alarm_mask_register(mask), .i_pattern_test_enable(test_en),
      .i_first_expect(e1), .i_second_expect(e2), .i_data_valid(valid),
      .i_first_pair_input_bus(w1), .i_second_pair_input_bus(w2),
      .i_transmit_enable_pin(pin), .o_serial_four_wire_select(four_w),
      .o_mixer_enable(mix), .o_mixer_gain_6db(gain), .o_nco_enable(nco),
      .o_coarse_current_code(code), .o_full_scale_steps(steps),
      .o_transmit_enable_internal(txint), .o_transmit_active(txact),
      .o_output_shutoff(shut), .o_first_pair_word(o1), .o_second_pair_word(o2));

   dcr_host_model host (.i_clk(clk), .i_four_wire(m02[7]), .o_sif_clk(sclk),
      .o_sif_enable_n(sen_n), .o_host_data(hdata), .i_shared_line(shared),
      .i_serial_out(so));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic wr(input logic [6:0] a, input logic [15:0] v);
      logic [15:0] r;
      host.frame(1'b0, a, v, r);
   endtask : wr

   task automatic rd_chk(input logic [6:0] a, input logic [15:0] exp);
      logic [15:0] r;
      host.frame(1'b1, a, 16'h0000, r);
      chk("read data", exp, r);
   endtask : rd_chk

   // reference word: optional reversal, then msb flip for two's complement
   function automatic logic [15:0] ref_word(input logic [15:0] w);
      logic [15:0] v;
      for (int b = 0; b < 16; b++) v[b] = m02[3] ? w[15-b] : w[b];
      v[15] = v[15] ^ m02[1];
      return v;
   endfunction : ref_word

   // back-to-back samples with random alarms and masks
   task automatic burst();
      logic sh;
      for (int k = 0; k < 4; k++) begin
         rnd = $random(seed);
         {dk, dt, cl} = rnd[2:0];
         mask = rnd[31:16] & 16'h2700;
         w1 = rnd[31:16];
         w2 = rnd[15:0] ^ 16'h5A3C;
         valid = 1'b1;
         sh = !mask[8] && ((m02[14] && dk && !mask[10]) || (m02[13] && dt && !mask[9])
              || (m02[12] && cl && !mask[13]));
         #1;
         chk("shutoff", {15'h0, sh}, {15'h0, shut});
         @(posedge clk);
         #1;
         chk("first word", sh ? 16'h8000 : ref_word(w1), o1);
         chk("second word", sh ? 16'h8000 : ref_word(w2), o2);
      end
      valid = 1'b0;
      {dk, dt, cl} = 3'b000;
   endtask : burst

   task automatic results();
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : results

   // watchdog well beyond the expected run length
   initial begin
      #200_000;
      n_mismatch++;
      results();
   end

   initial begin
      {dk, dt, cl, test_en, valid, pin} = 6'h00;
      {mask, e1, e2, w1, w2} = '0;
      m02 = 16'h7000;
      m03 = 16'hF000;
      rst_n = 1'b0;
      repeat (20) @(posedge clk);
      #1;
      rst_n = 1'b1;
      repeat (2) @(posedge clk);
      rd_chk(7'h02, 16'h7000);
      rd_chk(7'h03, 16'hF000);
      chk("steps", 16'd16, {11'h0, steps});
      // shutoff and format register, both serial widths
      for (int i = 0; i < 6; i++) begin
         rnd = $random(seed);
         d = (i == 0) ? 16'hFFFF : (i == 1) ? 16'h0000 : rnd[15:0];
         wr(7'h02, d);
         m02 = d & 16'h70FA;
         rd_chk(7'h02, m02);
         chk("config", {12'h0, m02[7:6], m02[5] & m02[6], m02[4]}, {12'h0, four_w, mix, gain, nco});
         burst();
      end
      // scale and transmit register with the pin both ways
      for (int i = 0; i < 5; i++) begin
         rnd = $random(seed);
         d = (i == 0) ? 16'h0001 : (i == 1) ? 16'hFFFE : rnd[15:0];
         wr(7'h03, d);
         m03 = d & 16'hF001;
         rd_chk(7'h03, m03);
         chk("steps", {12'h0, m03[15:12]} + 16'h1, {11'h0, steps});
         chk("coarse code", {12'h0, m03[15:12]}, {12'h0, code});
         chk("tx internal", {15'h0, m03[0]}, {15'h0, txint});
         for (int p = 0; p < 2; p++) begin
            pin = p[0];
            @(posedge clk);
            #1;
            chk("tx active", {15'h0, m03[0] | pin}, {15'h0, txact});
         end
      end
      // unmapped address reads as zero and leaves the scale register alone
      wr(7'h05, 16'hFFFF);
      rd_chk(7'h05, 16'h0000);
      rd_chk(7'h03, m03);
      // pattern test: sticky failures, then write-to-clear
      wr(7'h04, 16'h0000);
      test_en = 1'b1;
      pin = 1'b1;
      res = 16'h0000;
      @(posedge clk);
      #1;
      chk("tx in test", 16'h0000, {15'h0, txact});
      for (int k = 0; k < 6; k++) begin
         rnd = $random(seed);
         w1 = rnd[15:0];
         w2 = rnd[31:16];
         e1 = w1 ^ (16'h1 << rnd[3:0]);
         e2 = w2 ^ (16'h1 << rnd[7:4]);
         valid = (k < 2) | rnd[8];
         if (valid) res = res | (w1 ^ e1) | (w2 ^ e2);
         @(posedge clk);
         #1;
      end
      valid = 1'b0;
      test_en = 1'b0;
      pin = 1'b0;
      rd_chk(7'h04, res);
      rt = rnd[31:16];
      wr(7'h04, rt);
      rd_chk(7'h04, 16'h0000);
      results();
   end
endmodule : dac_config_control_regs_bench
